// file: hdl/jsrd_pkg.sv
/*
  Shared constants and carrier types for the boundary-scan test port.
  Assumes every user imports the whole package; no clocking of its own.
*/
package jsrd_pkg;

  // ==========================================================================
  // Widths and sizes
  localparam int JSRD_IR_W      = 4;   // Instruction register width
  localparam int JSRD_CMD_W     = 8;   // Vendor command register width
  localparam int JSRD_ID_W      = 32;  // Identification register width
  localparam int JSRD_NPINS     = 82;  // Scanned I/O pins
  localparam int JSRD_CELL_BITS = 3;   // Scan bits per boundary cell
  localparam int JSRD_SCAN_W    = 16;  // Vendor internal scan length
  localparam int JSRD_PROG_W    = 8;   // Programming word width
  localparam int JSRD_FIFO_D    = 16;  // Programming FIFO depth
  localparam int JSRD_SOFT_RST  = 5;   // TMS-high rising edges to reset

  // ==========================================================================
  // Instruction codes
  localparam logic [3:0] JSRD_IR_SAMPLE_PRELOAD             = 4'h1;
  localparam logic [3:0] JSRD_IR_IDCODE                     = 4'h2;
  localparam logic [3:0] JSRD_IR_EXTEST                     = 4'h3;
  localparam logic [3:0] JSRD_IR_HIGHZ                      = 4'h4;
  localparam logic [3:0] JSRD_IR_VENDOR_INTERNAL_SCAN_SELECT   = 4'h7;
  localparam logic [3:0] JSRD_IR_VENDOR_COMMAND_REGISTER_SELECT = 4'h8;
  localparam logic [3:0] JSRD_IR_BYPASS                     = 4'hF;
  localparam logic [3:0] JSRD_IR_CAPTURE                    = 4'h1;  // Fixed pattern on Capture-IR

  // ==========================================================================
  // Vendor commands and reset values
  localparam logic [7:0] JSRD_TEST_PORT_MASTER_RESET_COMMAND       = 8'h01;
  localparam logic [7:0] JSRD_SWITCH_TO_SERIAL_PROGRAMMING_COMMAND = 8'h02;
  localparam logic [7:0] JSRD_CMD_RESET                            = 8'h00;
  // Identification word; arbitrary neutral value, bit 0 kept high
  localparam logic [31:0] JSRD_IDCODE_DEFAULT = 32'h0ABC_DE01;

  // ==========================================================================
  // Test port controller states
  typedef enum logic [3:0] {
    JSRD_TLR    = 4'h0, JSRD_RTI    = 4'h1, JSRD_SEL_DR = 4'h2, JSRD_CAP_DR = 4'h3,
    JSRD_SH_DR  = 4'h4, JSRD_EX1_DR = 4'h5, JSRD_PAU_DR = 4'h6, JSRD_EX2_DR = 4'h7,
    JSRD_UPD_DR = 4'h8, JSRD_SEL_IR = 4'h9, JSRD_CAP_IR = 4'hA, JSRD_SH_IR  = 4'hB,
    JSRD_EX1_IR = 4'hC, JSRD_PAU_IR = 4'hD, JSRD_EX2_IR = 4'hE, JSRD_UPD_IR = 4'hF
  } jsrd_tap_t;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic capture;  // Capture-DR strobe
    logic shift;    // Shift strobe, chain selected
    logic update;   // Update-DR strobe
    logic sample;   // SAMPLE/PRELOAD active
    logic extest;   // EXTEST active
    logic highz;    // HIGHZ active
  } jsrd_dr_ctl_t;

  typedef struct packed {
    logic out;      // Output data
    logic oe;       // Output enable, high drives
  } jsrd_pad_t;

endpackage : jsrd_pkg

// file: hdl/jsrd_boundary_cell.sv
/*
  One boundary cell: three chained capture stages and two holding stages.
  Assumes strobes are one clk cycle wide, one per TCK edge.
*/
`timescale 1ns/1ps
module jsrd_boundary_cell
  import jsrd_pkg::*;
(
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         resetn_i,
  // Scan control and chain
  input  wire jsrd_dr_ctl_t ctl_i,
  input  wire logic         scan_i,
  output logic              scan_o,
  // Core and pad side
  input  wire jsrd_pad_t    core_i,
  input  wire logic         pad_in_i,
  output jsrd_pad_t         pad_o
);

  // ==========================================================================
  // State
  typedef struct packed {
    logic sync_m, sync_s;     // Pad input synchroniser
    logic cap_out, cap_oe;    // Stages one and two
    logic cap_in;             // Stage three
    logic hold_out, hold_oe;  // Holding stages
  } jsrd_cell_st_t;
  jsrd_cell_st_t q, d;
  logic          active;      // SAMPLE or EXTEST in force

  // Next state
  always_comb begin
    d        = q;
    active   = ctl_i.sample | ctl_i.extest;
    d.sync_m = pad_in_i;
    d.sync_s = q.sync_m;
    if (ctl_i.capture && active) begin
      d.cap_out = core_i.out;
      d.cap_oe  = core_i.oe;
      d.cap_in  = q.sync_s;
    end else if (ctl_i.shift) begin
      // Scan in at stage three, out of stage one
      d.cap_in  = scan_i;
      d.cap_oe  = q.cap_in;
      d.cap_out = q.cap_oe;
    end
    if (ctl_i.update && active) begin
      d.hold_out = q.cap_out;
      d.hold_oe  = q.cap_oe;
    end
  end

  // Registers
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // Pad drive: held stimulus wins as soon as EXTEST is latched
  always_comb begin
    if (ctl_i.extest) begin
      pad_o = '{out: q.hold_out, oe: q.hold_oe};
    end else if (ctl_i.highz) begin
      pad_o = '{out: core_i.out, oe: 1'b0};
    end else begin
      pad_o = core_i;
    end
  end
  assign scan_o = q.cap_out;

  // Assertions
  cell_highz_off_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    ctl_i.highz && !ctl_i.extest |-> !pad_o.oe) else $error("pad driven under HIGHZ");
  cell_extest_hold_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    ctl_i.update && ctl_i.extest |=> pad_o == $past({q.cap_out, q.cap_oe}))
    else $error("update did not reach pad");

endmodule : jsrd_boundary_cell

// file: hdl/jsrd_fifo.sv
/*
  Synchronous FIFO with valid/ready on both sides.
  Assumes one clock; a push into a full FIFO is refused.
*/
`timescale 1ns/1ps
module jsrd_fifo
  import jsrd_pkg::*;
#(
  parameter int W = JSRD_PROG_W,
  parameter int D = JSRD_FIFO_D
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         resetn_i,
  // Fill side
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  // Drain side
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o
);

  localparam int AW = $clog2(D);

  // ==========================================================================
  // Pointers carry one extra wrap bit
  typedef struct packed {
    logic [AW:0] wp, rp;
  } jsrd_fifo_st_t;
  jsrd_fifo_st_t q, d;
  logic [W-1:0]  mem [D];  // Storage
  logic          push, pop;

  always_comb begin
    in_ready_o  = !((q.wp[AW] != q.rp[AW]) && (q.wp[AW-1:0] == q.rp[AW-1:0]));
    out_valid_o = (q.wp != q.rp);
    push        = in_valid_i && in_ready_o;
    pop         = out_valid_o && out_ready_i;
    d           = q;
    if (push) d.wp = q.wp + 1'b1;
    if (pop)  d.rp = q.rp + 1'b1;
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // Memory has no reset, content only read when valid
  always_ff @(posedge clk_i) begin
    if (push) mem[q.wp[AW-1:0]] <= in_data_i;
  end
  assign out_data_o = mem[q.rp[AW-1:0]];

endmodule : jsrd_fifo

// file: hdl/jsrd_tap.sv
/*
  Boundary-scan test port: controller, instruction decode, data registers,
  boundary chain and serial programming switch-over.
  Assumes TCK, TMS, TDI arrive unsynchronised and TCK is far slower than clk_i.
*/
// Function
// - Four-bit instruction register selects data path
// - Instruction latch changes only Update-IR, reset
// - No register reachable from firmware memory
// - BYPASS 0x0F gives one-bit path
// - Eight-bit command register with separate latch
// - IDCODE 0x02 shifts 32-bit identity out
// - Chain holds three bits per pin
// - SAMPLE/PRELOAD and EXTEST select boundary chain
// - Supply and test pins have no cell
// - Cell has three capture, two holding stages
// - Stages: output, output enable, input
// - SAMPLE captures pins on Capture-DR rise
// - Preloaded data drives pins when EXTEST latches
// - EXTEST drives outputs, captures inputs
// - HIGHZ floats outputs, bypass in path
// - Code 0x07 selects vendor internal scan
// - Code 0x08 selects vendor command register
// - Command 0x01 master resets, port untouched
// - Command 0x02 enters serial programming mode
// - Cells capture and override under controller strobes
// - Serial data least significant bit first
// - TDO floats outside shifts unless programming, falls-edge updates
// - Five TMS-high rises reset the port outside programming mode
// - Sixteen-state controller, transitions on TCK rise
`timescale 1ns/1ps
module jsrd_tap
  import jsrd_pkg::*;
#(
  parameter int          NPINS  = JSRD_NPINS,
  parameter int          SCAN_W = JSRD_SCAN_W,
  parameter logic [31:0] IDCODE = JSRD_IDCODE_DEFAULT  // Arbitrary value
) (
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              resetn_i,
  // Test port pins
  input  wire logic              tck_i,
  input  wire logic              tms_i,
  input  wire logic              tdi_i,
  output logic                   tdo_o,
  output logic                   tdo_oe_o,
  // Scanned I/O (power and test pins excluded)
  input  wire jsrd_pad_t [NPINS-1:0] core_pad_i,
  input  wire logic [NPINS-1:0]  pad_in_i,
  output jsrd_pad_t [NPINS-1:0]  pad_o,
  // Device reset request
  output logic                   core_reset_o,
  // Serial programming
  output logic                   prog_mode_o,
  output logic                   prog_clk_o,
  input  wire logic              prog_dout_i,
  output logic                   prog_valid_o,
  input  wire logic              prog_ready_i,
  output logic [JSRD_PROG_W-1:0] prog_data_o,
  output logic                   prog_wr_ready_o,
  output logic                   prog_overflow_o
);

  // ==========================================================================
  // State
  typedef struct packed {
    logic                  tck_m, tck_s, tck_p;  // TCK synchroniser and history
    logic                  tms_m, tms_s;         // TMS synchroniser
    logic                  tdi_m, tdi_s;         // TDI synchroniser
    jsrd_tap_t             tap;                  // Controller state
    logic [JSRD_IR_W-1:0]  ir_sh;                // Instruction shift stages
    logic [JSRD_IR_W-1:0]  ir;                   // Instruction latch
    logic                  byp;                  // Bypass stage
    logic [JSRD_ID_W-1:0]  id_sh;                // Identification shifter
    logic [JSRD_CMD_W-1:0] cmd_sh;               // Vendor command shifter
    logic [JSRD_CMD_W-1:0] cmd;                  // Vendor command latch
    logic [SCAN_W-1:0]     scan_sh;              // Vendor internal scan
    logic                  tdo, tdo_oe;          // Pin drive
    logic                  prog;                 // Programming mode, sticky
    logic [JSRD_PROG_W-1:0] pbyte;               // Programming bit gatherer
    logic [2:0]            pcnt;                 // Bits gathered
    logic                  push;                 // Word ready for FIFO
    logic                  ovf;                  // Word lost, sticky
  } jsrd_st_t;
  jsrd_st_t q, d;

  logic             rise, fall;    // TCK edges seen in clk domain
  logic             fifo_ready;    // FIFO can take a word
  logic             sel_bnd;       // Boundary chain selected
  logic             dr_bit;        // Selected data register output bit
  jsrd_dr_ctl_t     ctl;           // Strobes to the cells
  logic [NPINS:0]   chain;         // Scan chain taps, TDI enters at top

  // ==========================================================================
  // Controller next state on TMS
  function automatic jsrd_tap_t next_tap(input jsrd_tap_t s, input logic tms);
    case (s)
      JSRD_TLR:    next_tap = tms ? JSRD_TLR    : JSRD_RTI;
      JSRD_RTI:    next_tap = tms ? JSRD_SEL_DR : JSRD_RTI;
      JSRD_SEL_DR: next_tap = tms ? JSRD_SEL_IR : JSRD_CAP_DR;
      JSRD_CAP_DR: next_tap = tms ? JSRD_EX1_DR : JSRD_SH_DR;
      JSRD_SH_DR:  next_tap = tms ? JSRD_EX1_DR : JSRD_SH_DR;
      JSRD_EX1_DR: next_tap = tms ? JSRD_UPD_DR : JSRD_PAU_DR;
      JSRD_PAU_DR: next_tap = tms ? JSRD_EX2_DR : JSRD_PAU_DR;
      JSRD_EX2_DR: next_tap = tms ? JSRD_UPD_DR : JSRD_SH_DR;
      JSRD_UPD_DR: next_tap = tms ? JSRD_SEL_DR : JSRD_RTI;
      JSRD_SEL_IR: next_tap = tms ? JSRD_TLR    : JSRD_CAP_IR;
      JSRD_CAP_IR: next_tap = tms ? JSRD_EX1_IR : JSRD_SH_IR;
      JSRD_SH_IR:  next_tap = tms ? JSRD_EX1_IR : JSRD_SH_IR;
      JSRD_EX1_IR: next_tap = tms ? JSRD_UPD_IR : JSRD_PAU_IR;
      JSRD_PAU_IR: next_tap = tms ? JSRD_EX2_IR : JSRD_PAU_IR;
      JSRD_EX2_IR: next_tap = tms ? JSRD_UPD_IR : JSRD_SH_IR;
      JSRD_UPD_IR: next_tap = tms ? JSRD_SEL_DR : JSRD_RTI;
      default:     next_tap = JSRD_TLR;
    endcase
  endfunction : next_tap

  // ==========================================================================
  // Decode and cell strobes; programming mode freezes the controller
  always_comb begin
    rise    = q.tck_s & ~q.tck_p;
    fall    = ~q.tck_s & q.tck_p;
    sel_bnd = (q.ir == JSRD_IR_SAMPLE_PRELOAD) || (q.ir == JSRD_IR_EXTEST);
    ctl.capture = rise && !q.prog && (q.tap == JSRD_CAP_DR);
    ctl.shift   = rise && !q.prog && (q.tap == JSRD_SH_DR) && sel_bnd;
    ctl.update  = rise && !q.prog && (q.tap == JSRD_UPD_DR);
    ctl.sample  = (q.ir == JSRD_IR_SAMPLE_PRELOAD);
    ctl.extest  = (q.ir == JSRD_IR_EXTEST);
    ctl.highz   = (q.ir == JSRD_IR_HIGHZ);
    // Serial path per instruction; anything unlisted falls to bypass
    case (q.ir)
      JSRD_IR_SAMPLE_PRELOAD,
      JSRD_IR_EXTEST:                        dr_bit = chain[0];
      JSRD_IR_IDCODE:                        dr_bit = q.id_sh[0];
      JSRD_IR_VENDOR_INTERNAL_SCAN_SELECT:   dr_bit = q.scan_sh[0];
      JSRD_IR_VENDOR_COMMAND_REGISTER_SELECT: dr_bit = q.cmd_sh[0];
      default:                               dr_bit = q.byp;
    endcase
  end

  // ==========================================================================
  // Boundary chain: one cell per scanned pin, three bits each
  assign chain[NPINS] = q.tdi_s;
  for (genvar i = 0; i < NPINS; i++) begin : g_cell
    jsrd_boundary_cell u_cell (
      .clk_i    (clk_i),
      .resetn_i (resetn_i),
      .ctl_i    (ctl),
      .scan_i   (chain[i+1]),
      .scan_o   (chain[i]),
      .core_i   (core_pad_i[i]),
      .pad_in_i (pad_in_i[i]),
      .pad_o    (pad_o[i])
    );
  end

  // ==========================================================================
  // Next state of the port
  always_comb begin
    d        = q;
    d.push   = 1'b0;
    // Two-stage synchronisers; only the second stages and the TCK history stage feed logic
    d.tck_m  = tck_i;
    d.tck_s  = q.tck_m;
    d.tck_p  = q.tck_s;
    d.tms_m  = tms_i;
    d.tms_s  = q.tms_m;
    d.tdi_m  = tdi_i;
    d.tdi_s  = q.tdi_m;
    // Test-Logic-Reset forces IDCODE and clears the command latch
    if (q.tap == JSRD_TLR) begin
      d.ir  = JSRD_IR_IDCODE;
      d.cmd = JSRD_CMD_RESET;
    end
    if (q.prog) begin
      // Programming: TDI data in, gathered LSB first into words
      if (rise) begin
        d.pbyte = {q.tdi_s, q.pbyte[JSRD_PROG_W-1:1]};
        d.pcnt  = q.pcnt + 3'h1;
        d.push  = (q.pcnt == 3'h7);
      end
      if (fall) begin
        d.tdo    = prog_dout_i;
        d.tdo_oe = 1'b1;
      end
      if (q.push && !fifo_ready) d.ovf = 1'b1;
    end else begin
      if (rise) begin
        d.tap = next_tap(q.tap, q.tms_s);
        case (q.tap)
          JSRD_CAP_IR: d.ir_sh = JSRD_IR_CAPTURE;
          JSRD_SH_IR:  d.ir_sh = {q.tdi_s, q.ir_sh[JSRD_IR_W-1:1]};
          JSRD_UPD_IR: d.ir    = q.ir_sh;
          JSRD_CAP_DR: begin
            d.byp   = 1'b0;
            d.id_sh = IDCODE;
            d.cmd_sh = q.cmd;
          end
          JSRD_SH_DR: begin
            // Only the selected register moves; all shift right
            case (q.ir)
              JSRD_IR_SAMPLE_PRELOAD, JSRD_IR_EXTEST: ;              // Cells shift
              JSRD_IR_IDCODE:
                d.id_sh = {q.tdi_s, q.id_sh[JSRD_ID_W-1:1]};
              JSRD_IR_VENDOR_INTERNAL_SCAN_SELECT:
                d.scan_sh = {q.tdi_s, q.scan_sh[SCAN_W-1:1]};
              JSRD_IR_VENDOR_COMMAND_REGISTER_SELECT:
                d.cmd_sh = {q.tdi_s, q.cmd_sh[JSRD_CMD_W-1:1]};
              default:
                d.byp = q.tdi_s;
            endcase
          end
          JSRD_UPD_DR: begin
            if (q.ir == JSRD_IR_VENDOR_COMMAND_REGISTER_SELECT) begin
              // Latched only here, so partial patterns never act
              d.cmd = q.cmd_sh;
              if (q.cmd_sh == JSRD_SWITCH_TO_SERIAL_PROGRAMMING_COMMAND) begin
                d.prog  = 1'b1;
                d.pcnt  = 3'h0;
              end
            end
          end
          default: ;
        endcase
      end
      // TDO follows falling edges, floats outside the shift states
      if (fall) begin
        d.tdo_oe = (q.tap == JSRD_SH_IR) || (q.tap == JSRD_SH_DR);
        d.tdo    = (q.tap == JSRD_SH_IR) ? q.ir_sh[0] : dr_bit;
      end
    end
  end

  // Registers; resetn_i is the power-up reset only, the vendor reset
  // request never comes back here so the port survives it
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      q     <= '0;
      q.ir  <= JSRD_IR_IDCODE;
      q.tap <= JSRD_TLR;
    end else begin
      q <= d;
    end
  end

  // ==========================================================================
  // Programming word FIFO; back-pressure shows on prog_wr_ready_o
  jsrd_fifo #(
    .W (JSRD_PROG_W),
    .D (JSRD_FIFO_D)
  ) u_fifo (
    .clk_i       (clk_i),
    .resetn_i    (resetn_i),
    .in_valid_i  (q.push),
    .in_ready_o  (fifo_ready),
    .in_data_i   (q.pbyte),
    .out_valid_o (prog_valid_o),
    .out_ready_i (prog_ready_i),
    .out_data_o  (prog_data_o)
  );

  // ==========================================================================
  // Outputs; no register here sits on any firmware bus
  assign tdo_o           = q.tdo;
  assign tdo_oe_o        = q.tdo_oe;
  assign core_reset_o    = (q.cmd == JSRD_TEST_PORT_MASTER_RESET_COMMAND);
  assign prog_mode_o     = q.prog;
  assign prog_clk_o      = q.prog & q.tck_p;  // TCK doubles as programming clock
  assign prog_wr_ready_o = fifo_ready;
  assign prog_overflow_o = q.ovf;

  // ==========================================================================
  // Assertion helper: consecutive TCK rises with TMS high
  logic [2:0] tms_hi_cnt;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tms_hi_cnt <= 3'h0;
    end else if (rise) begin
      tms_hi_cnt <= !q.tms_s ? 3'h0 : (tms_hi_cnt == 3'h5) ? 3'h5 : tms_hi_cnt + 3'h1;
    end
  end

  ir_latch_hold_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    $changed(q.ir) |-> $past(q.tap) inside {JSRD_UPD_IR, JSRD_TLR}) else $error("IR latch moved");
  bypass_one_bit_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    rise && !q.prog && q.tap == JSRD_SH_DR && q.ir == JSRD_IR_BYPASS |=> q.byp == $past(q.tdi_s))
    else $error("bypass stage not loaded");
  idcode_load_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    rise && !q.prog && q.tap == JSRD_CAP_DR |=> q.id_sh == IDCODE) else $error("identity not captured");
  cmd_latch_hold_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    $changed(q.cmd) |-> $past(q.tap) inside {JSRD_UPD_DR, JSRD_TLR}) else $error("command latch moved");
  master_reset_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    rise && !q.prog && q.tap == JSRD_UPD_DR && q.ir == JSRD_IR_VENDOR_COMMAND_REGISTER_SELECT
    && q.cmd_sh == JSRD_TEST_PORT_MASTER_RESET_COMMAND |=> core_reset_o && (q.tap == JSRD_RTI || q.tap == JSRD_SEL_DR))
    else $error("master reset not raised");
  prog_sticky_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    prog_mode_o |=> prog_mode_o && (tdo_oe_o == $past(tdo_oe_o) || $past(fall))) else $error("left programming mode");
  tdo_float_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    fall && !q.prog && !(q.tap inside {JSRD_SH_IR, JSRD_SH_DR}) |=> !tdo_oe_o ##1 ($stable(tdo_o) || $past(fall)))
    else $error("TDO driven outside shift");
  soft_reset_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    tms_hi_cnt == 3'h5 && !q.prog |-> q.tap == JSRD_TLR) else $error("five TMS highs did not reset");

endmodule : jsrd_tap

// file: testbench/jsrd_tester.sv
/* External test controller model: drives TCK, TMS, TDI and reads TDO.
   Assumes the bench clock paces it; TCK period is 8 bench clocks. */
`timescale 1ns/1ps
module jsrd_tester (
  // Bench clock
  input  wire logic clk_i,
  // Test port pins
  output logic      tck_o,
  output logic      tms_o,
  output logic      tdi_o,
  input  wire logic tdo_i
);
  // ==========================================================================
  // Pin drivers
  // TCK parks low between frames
  initial begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b0;
  end
  // One TCK period, TMS/TDI held 4 clocks either side of the rise
  task automatic bit_cyc(input logic tms, input logic tdi, output logic tdo);
    tms_o = tms;
    tdi_o = tdi;
    repeat (4) @(negedge clk_i);
    tdo = tdo_i;
    tck_o = 1'b1;
    repeat (4) @(negedge clk_i);
    tck_o = 1'b0;
  endtask : bit_cyc
  // Five TMS-high rises, then idle; TDI toggles when unused
  task automatic tap_reset();
    logic d;
    repeat (5) bit_cyc(1'b1, ~tdi_o, d);
    bit_cyc(1'b0, ~tdi_o, d);
  endtask : tap_reset
  // Idle to idle scan, least significant bit first both ways
  task automatic scan(input logic ir, input int n, input logic [255:0] din, output logic [255:0] dout);
    logic d;
    dout = '0;
    bit_cyc(1'b1, ~tdi_o, d);
    if (ir) bit_cyc(1'b1, ~tdi_o, d);
    bit_cyc(1'b0, ~tdi_o, d);
    bit_cyc(1'b0, ~tdi_o, d);
    for (int i = 0; i < n; i++) begin
      bit_cyc(i == n - 1, din[i], d);
      dout[i] = d;
    end
    bit_cyc(1'b1, ~tdi_o, d);
    bit_cyc(1'b0, ~tdi_o, d);
  endtask : scan
endmodule : jsrd_tester

// file: testbench/jsrd_tap_test.sv
/* Self-checking bench for the test port and its programming buffer.
   Assumes jsrd_pkg and jsrd_tester are compiled before it. */
`timescale 1ns/1ps
module jsrd_tap_test
  import jsrd_pkg::*;
;
  localparam int      NP = JSRD_NPINS;
  logic               clk, resetn, tck, tms, tdi, tdo, tdo_oe, core_rst, pmode;
  logic               pvalid, pready, pwr_rdy, povf, pdout, pclk;
  logic [7:0]         pdata;
  logic [NP-1:0]      pad_in;
  jsrd_pad_t [NP-1:0] core_pad, pad_o;
  logic [255:0]       o, p, e, q;
  int                 failures, checked;
  jsrd_tap i_dut (.clk_i(clk), .resetn_i(resetn), .tck_i(tck), .tms_i(tms), .tdi_i(tdi), .tdo_o(tdo),
    .tdo_oe_o(tdo_oe), .core_pad_i(core_pad), .pad_in_i(pad_in), .pad_o(pad_o), .core_reset_o(core_rst),
    .prog_mode_o(pmode), .prog_clk_o(pclk), .prog_dout_i(pdout), .prog_valid_o(pvalid), .prog_ready_i(pready),
    .prog_data_o(pdata), .prog_wr_ready_o(pwr_rdy), .prog_overflow_o(povf));
  // TDO line is pulled up while the port floats it, so a late enable shows as ones
  jsrd_tester i_tester (.clk_i(clk), .tck_o(tck), .tms_o(tms), .tdi_o(tdi), .tdo_i(tdo_oe ? tdo : 1'b1));
  // ==========================================================================
  // Checking and verdict
  always #25 clk = ~clk;
  task automatic check(input logic [255:0] seen, input logic [255:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask : check
  task automatic summarize();
    if (failures == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : summarize
  // Instruction scan; Capture-IR pattern out, TDO floats after
  task automatic load_ir(input logic [3:0] code);
    i_tester.scan(1'b1, 4, {252'h0, code}, o);
    check(o, 256'h1);
    check(tdo_oe, 1'b0);
  endtask : load_ir
  // ==========================================================================
  // Scenarios
  // Sample with preload, then EXTEST drives the preload at once
  task automatic t_boundary();
    p = {64{4'hC}};
    e = '0;
    q = '0;
    for (int k = 0; k < NP; k++) begin
      e[3*k +: 3] = {pad_in[k], core_pad[k].oe, core_pad[k].out};
      q[2*k +: 2] = {p[3*k], p[3*k+1]};
    end
    load_ir(JSRD_IR_SAMPLE_PRELOAD);
    i_tester.scan(1'b0, 3 * NP, p, o);
    check(o, e);
    check(pad_o, core_pad);
    load_ir(JSRD_IR_EXTEST);
    check(pad_o, q);
    i_tester.scan(1'b0, 3 * NP, p, o);
    check(o, e);
  endtask : t_boundary
  // One-bit path for bypass, an unlisted code and HIGHZ
  task automatic t_bypass();
    logic [3:0] codes [3] = '{JSRD_IR_BYPASS, 4'h5, JSRD_IR_HIGHZ};
    for (int i = 0; i < 3; i++) begin
      load_ir(codes[i]);
      i_tester.scan(1'b0, 3, 256'h5, o);
      check(o[2:1], 2'b01);
    end
    for (int k = 0; k < NP; k++) q[k] = pad_o[k].oe;
    check(q[NP-1:0], '0);
    load_ir(JSRD_IR_VENDOR_INTERNAL_SCAN_SELECT);
    i_tester.scan(1'b0, JSRD_SCAN_W, 256'hA5C3, o);
    i_tester.scan(1'b0, JSRD_SCAN_W, 256'h0, o);
    check(o, 256'hA5C3);
  endtask : t_bypass
  // Master reset, ignored code, then switch to programming
  task automatic t_vendor();
    load_ir(JSRD_IR_VENDOR_COMMAND_REGISTER_SELECT);
    i_tester.scan(1'b0, 8, 256'h01, o);
    check(core_rst, 1'b1);
    i_tester.scan(1'b0, 8, 256'h55, o);
    check(o, 256'h01);
    check(core_rst, 1'b0);
    i_tester.scan(1'b0, 8, 256'h02, o);
    check(pmode, 1'b1);
  endtask : t_vendor
  // Overfill the buffer with TMS high, then drain it
  task automatic t_prog();
    logic d;
    pdout = 1'b1;
    fork
      for (int w = 0; w < 17; w++)
        for (int b = 0; b < 8; b++) i_tester.bit_cyc(1'b1, w * 17 >> b, d);
      begin
        repeat (7) @(negedge clk);
        check(pclk, 1'b1);
      end
    join
    repeat (4) @(negedge clk);
    check({pvalid, pwr_rdy, povf, tdo_oe, tdo, pclk}, 6'b101110);
    for (int w = 0; w < 16; w++) begin
      check({pvalid, pdata}, {1'b1, 8'(w * 17)});
      pready = 1'b1;
      @(negedge clk);
      pready = 1'b0;
      @(negedge clk);
    end
    check(pvalid, 1'b0);
  endtask : t_prog
  // ==========================================================================
  // Main sequence and watchdog
  initial begin
    clk = 1'b0;
    resetn = 1'b0;
    pready = 1'b0;
    pdout = 1'b0;
    core_pad = {41{4'hB}};
    pad_in = {41{2'h1}};
    failures = 0;
    checked = 0;
    repeat (6) @(negedge clk);
    resetn = 1'b1;
    check({tdo_oe, core_rst, pmode}, 3'b000);
    i_tester.tap_reset();
    i_tester.scan(1'b0, 32, '0, o);
    check(o, JSRD_IDCODE_DEFAULT);
    t_boundary();
    t_bypass();
    i_tester.tap_reset();
    i_tester.scan(1'b0, 32, '0, o);
    check(o, JSRD_IDCODE_DEFAULT);
    t_vendor();
    t_prog();
    summarize();
  end
  // Run needs about 0.36 ms; a hang is cut at 3 ms
  initial begin
    #3_000_000;
    failures++;
    summarize();
  end
endmodule : jsrd_tap_test
